// >>> verilog/port_phy_map.svh
/*
 * Register offsets, field positions, reset values and read and indicator
 * constants for the per-port PHY control and status bank.
 * Assumes an 8-bit register address space and byte-wide registers.
 */
`ifndef PORT_PHY_MAP_SVH
`define PORT_PHY_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PORT1_NEG_ADVERTISE_OFS 8'h1C
`define PORT1_PHY_CONTROL_B_OFS 8'h1D
`define PORT1_PHY_STATUS_A_OFS 8'h1E
`define PORT2_NEG_ADVERTISE_OFS 8'h2C
`define PORT2_PHY_CONTROL_B_OFS 8'h2D
`define PORT2_PHY_STATUS_A_OFS 8'h2E

// ****************************************************************
// Negotiation advertise register fields
// ****************************************************************
`define ADV_NEG_ENABLE_BIT 7
`define ADV_FORCE_SPEED_BIT 6
`define ADV_FORCE_DUPLEX_BIT 5
`define ADV_PAUSE_BIT 4
`define ADV_100_FULL_BIT 3
`define ADV_100_HALF_BIT 2
`define ADV_10_FULL_BIT 1
`define ADV_10_HALF_BIT 0
`define ADV_RESET 8'h0F

// ****************************************************************
// Control B register fields
// ****************************************************************
`define CTL_LED_OFF_BIT 7
`define CTL_TX_DISABLE_BIT 6
`define CTL_NEG_RESTART_BIT 5
`define CTL_FEF_DISABLE_BIT 4
`define CTL_POWER_DOWN_BIT 3
`define CTL_XOVER_DISABLE_BIT 2
`define CTL_FORCE_MDI_BIT 1
`define CTL_LOOPBACK_BIT 0
`define CTL_RESET 8'h00

// ****************************************************************
// Status A register fields
// ****************************************************************
`define STS_XOVER_BIT 7
`define STS_NEG_DONE_BIT 6
`define STS_RESET 8'h00

// ****************************************************************
// Miscellaneous values
// ****************************************************************
`define READ_UNMAPPED 8'h00
`define INDICATOR_BLANK 4'hF

`endif

// >>> verilog/port_phy_pkg.sv
/*
 * Types shared by the per-port PHY control and status bank.
 * Assumes the constants in port_phy_map.svh.
 */
package port_phy_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] indicator_t;

endpackage : port_phy_pkg

// >>> verilog/port_phy_control_status.sv
/*
 * Per-port PHY control and status register bank for two copper ports,
 * the first also fiber capable, with PHY-facing control outputs.
 * Writes to status or unmapped addresses are ignored, unmapped reads
 * return zero, and the restart bit reads back as one only in the
 * cycle after it is written.
 * Reads answer one cycle after the read strobe and then hold.
 * Assumes a synchronous byte register port driven by the management
 * logic, PHY status levels synchronous to clk, and strap levels
 * stable around reset release.
 */
`timescale 1ns/1ps
`include "port_phy_map.svh"

module port_phy_control_status (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register access port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_write_data,
  output logic [7:0] reg_read_data,
  // Strap pins sampled at reset release.
  input wire logic port1_negotiation_strap,
  input wire logic port2_negotiation_strap,
  input wire logic port2_crossover_strap,
  input wire logic port2_force_mdi_strap,
  // Status from the PHYs, index 0 is the first port.
  input wire logic [1:0] phy_crossover_mdix,
  input wire logic [1:0] phy_negotiation_complete,
  // Raw indicator levels from the PHYs.
  input wire logic [3:0] port1_indicator_raw,
  input wire logic [3:0] port2_indicator_raw,
  // Indicator pins.
  output logic [3:0] port1_indicator_pin,
  output logic [3:0] port2_indicator_pin,
  // Control to the PHYs, index 0 is the first port.
  output logic [1:0] advertise_10_full,
  output logic [1:0] advertise_10_half,
  output logic [1:0] advertise_100_full,
  output logic [1:0] advertise_100_half,
  output logic [1:0] advertise_pause,
  output logic [1:0] negotiation_enable,
  output logic [1:0] force_speed_100,
  output logic [1:0] force_full_duplex,
  output logic [1:0] transmit_disable,
  output logic [1:0] negotiation_restart,
  output logic [1:0] power_down,
  output logic [1:0] crossover_auto_enable,
  output logic [1:0] force_mdi,
  output logic [1:0] loopback_enable,
  output logic port1_far_end_fault_disable
);

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic strap_taken;
  logic next_strap_taken;
  logic [1:0] neg_strap;
  logic [1:0] xover_strap;
  logic [1:0] mdi_strap;

  always_comb begin
    // Straps are loaded only on the first edge after reset release.
    next_strap_taken = 1'b1;
  end

  always_comb begin
    neg_strap = {port2_negotiation_strap, port1_negotiation_strap};
    xover_strap = {port2_crossover_strap, 1'b0};
    mdi_strap = {port2_force_mdi_strap, 1'b0};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= next_strap_taken;
    end
  end

  // ****************************************************************
  // Per-port registers
  // ****************************************************************
  port_phy_pkg::reg_byte_t adv [2];
  port_phy_pkg::reg_byte_t ctl [2];
  port_phy_pkg::reg_byte_t sts [2];
  port_phy_pkg::indicator_t ind_raw [2];
  port_phy_pkg::indicator_t ind_pin [2];

  // ****************************************************************
  // Indicator pin mapping
  // ****************************************************************
  always_comb begin
    ind_raw[0] = port1_indicator_raw;
    ind_raw[1] = port2_indicator_raw;
  end

  always_comb begin
    port1_indicator_pin = ind_pin[0];
    port2_indicator_pin = ind_pin[1];
  end

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      localparam logic [7:0] ADV_OFS = (p == 0) ? `PORT1_NEG_ADVERTISE_OFS : `PORT2_NEG_ADVERTISE_OFS;
      localparam logic [7:0] CTL_OFS = (p == 0) ? `PORT1_PHY_CONTROL_B_OFS : `PORT2_PHY_CONTROL_B_OFS;
      port_phy_pkg::reg_byte_t next_adv;
      port_phy_pkg::reg_byte_t next_ctl;
      port_phy_pkg::reg_byte_t next_sts;
      port_phy_pkg::indicator_t next_ind;
      logic adv_hit;
      logic ctl_hit;

      // ****************************************************************
      // Write decode
      // ****************************************************************
      always_comb begin
        adv_hit = reg_write && (reg_addr == ADV_OFS);
        ctl_hit = reg_write && (reg_addr == CTL_OFS);
      end

      // ****************************************************************
      // Negotiation advertise register
      // ****************************************************************
      always_comb begin
        next_adv = adv[p];
        if (adv_hit) begin
          next_adv = reg_write_data;
        end
        if (!strap_taken) begin
          next_adv[`ADV_NEG_ENABLE_BIT] = neg_strap[p];
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          adv[p] <= `ADV_RESET;
        end else begin
          adv[p] <= next_adv;
        end
      end

      // ****************************************************************
      // Control B register
      // ****************************************************************
      always_comb begin
        next_ctl = ctl[p];
        // Restart is a one-cycle request and clears itself.
        next_ctl[`CTL_NEG_RESTART_BIT] = 1'b0;
        if (ctl_hit) begin
          next_ctl = reg_write_data;
          if (p != 0) begin
            next_ctl[`CTL_FEF_DISABLE_BIT] = 1'b0;
          end
        end
        if (!strap_taken) begin
          next_ctl[`CTL_XOVER_DISABLE_BIT] = xover_strap[p];
          next_ctl[`CTL_FORCE_MDI_BIT] = mdi_strap[p];
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ctl[p] <= `CTL_RESET;
        end else begin
          ctl[p] <= next_ctl;
        end
      end

      // ****************************************************************
      // Status A register
      // ****************************************************************
      always_comb begin
        next_sts = `STS_RESET;
        next_sts[`STS_XOVER_BIT] = phy_crossover_mdix[p];
        next_sts[`STS_NEG_DONE_BIT] = phy_negotiation_complete[p];
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sts[p] <= `STS_RESET;
        end else begin
          sts[p] <= next_sts;
        end
      end

      // ****************************************************************
      // Indicator pins
      // ****************************************************************
      always_comb begin
        // Blanked indicators are driven high.
        next_ind = ctl[p][`CTL_LED_OFF_BIT] ? `INDICATOR_BLANK : ind_raw[p];
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ind_pin[p] <= `INDICATOR_BLANK;
        end else begin
          ind_pin[p] <= next_ind;
        end
      end

      // ****************************************************************
      // PHY advertise outputs
      // ****************************************************************
      always_comb begin
        advertise_10_full[p] = adv[p][`ADV_10_FULL_BIT];
        advertise_10_half[p] = adv[p][`ADV_10_HALF_BIT];
        advertise_100_full[p] = adv[p][`ADV_100_FULL_BIT];
        advertise_100_half[p] = adv[p][`ADV_100_HALF_BIT];
        advertise_pause[p] = adv[p][`ADV_PAUSE_BIT];
        negotiation_enable[p] = adv[p][`ADV_NEG_ENABLE_BIT];
        force_speed_100[p] = adv[p][`ADV_FORCE_SPEED_BIT];
        force_full_duplex[p] = adv[p][`ADV_FORCE_DUPLEX_BIT];
      end

      // ****************************************************************
      // PHY control outputs
      // ****************************************************************
      always_comb begin
        transmit_disable[p] = ctl[p][`CTL_TX_DISABLE_BIT];
        negotiation_restart[p] = ctl[p][`CTL_NEG_RESTART_BIT];
        power_down[p] = ctl[p][`CTL_POWER_DOWN_BIT];
        crossover_auto_enable[p] = !ctl[p][`CTL_XOVER_DISABLE_BIT];
        force_mdi[p] = ctl[p][`CTL_FORCE_MDI_BIT];
      end
    end
  endgenerate

  // ****************************************************************
  // Loopback
  // ****************************************************************
  always_comb begin
    // Each port's loopback bit drives its own PHY's loopback_enable.
    loopback_enable[0] = ctl[0][`CTL_LOOPBACK_BIT];
    loopback_enable[1] = ctl[1][`CTL_LOOPBACK_BIT];
  end

  // ****************************************************************
  // Far-end fault
  // ****************************************************************
  always_comb begin
    // Only the first port can carry fiber, so only it has this control.
    port1_far_end_fault_disable = ctl[0][`CTL_FEF_DISABLE_BIT];
  end

  // ****************************************************************
  // Register read path
  // ****************************************************************
  port_phy_pkg::reg_byte_t read_mux;
  port_phy_pkg::reg_byte_t next_read_data;

  always_comb begin
    unique case (reg_addr)
      `PORT1_NEG_ADVERTISE_OFS: read_mux = adv[0];
      `PORT1_PHY_CONTROL_B_OFS: read_mux = ctl[0];
      `PORT1_PHY_STATUS_A_OFS: read_mux = sts[0];
      `PORT2_NEG_ADVERTISE_OFS: read_mux = adv[1];
      `PORT2_PHY_CONTROL_B_OFS: read_mux = ctl[1];
      `PORT2_PHY_STATUS_A_OFS: read_mux = sts[1];
      default: read_mux = `READ_UNMAPPED;
    endcase
  end

  always_comb begin
    // Read data holds between reads.
    next_read_data = reg_read_data;
    if (reg_read) begin
      next_read_data = read_mux;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_read_data <= `READ_UNMAPPED;
    end else begin
      reg_read_data <= next_read_data;
    end
  end

endmodule : port_phy_control_status

// >>> testbench/port_phy_properties.sv
/* Checker for the port PHY register bank ports.
   Assumes binding to port_phy_control_status. */
`timescale 1ns/1ps
module port_phy_properties (
  // Clock, reset and register port.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  // PHY side.
  input wire logic [1:0] phy_crossover_mdix,
  input wire logic [1:0] phy_negotiation_complete,
  input wire logic [3:0] port1_indicator_pin,
  input wire logic [1:0] advertise_10_full,
  input wire logic [1:0] transmit_disable,
  input wire logic [1:0] negotiation_restart,
  input wire logic [1:0] crossover_auto_enable,
  input wire logic [1:0] force_mdi,
  input wire logic [1:0] loopback_enable,
  input wire logic [3:0] port1_indicator_raw,
  input wire logic [1:0] advertise_10_half,
  input wire logic [1:0] negotiation_enable,
  input wire logic [1:0] power_down,
  input wire logic port1_far_end_fault_disable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire w1c = reg_write && reg_addr == 8'h1C;
  wire w1d = reg_write && reg_addr == 8'h1D;
  wire w2d = reg_write && reg_addr == 8'h2D;
  wire w2c = reg_write && reg_addr == 8'h2C;
  property p_adv; w1c |=> advertise_10_full[0] == $past(reg_write_data[1]); endproperty
  a_adv: assert property (p_adv) else $error("advertise bit wrong");
  property p_led; w1d && reg_write_data[7] |=> ##1 port1_indicator_pin == 4'hF; endproperty
  a_led: assert property (p_led) else $error("indicators not blanked");
  property p_tx; w2d |=> transmit_disable[1] == $past(reg_write_data[6]); endproperty
  a_tx: assert property (p_tx) else $error("transmit disable wrong");
  property p_rst; w2d && reg_write_data[5] |=> negotiation_restart[1]; endproperty
  a_rst: assert property (p_rst) else $error("restart missing");
  property p_rst1; negotiation_restart[0] |-> $past(w1d && reg_write_data[5]); endproperty
  a_rst1: assert property (p_rst1) else $error("restart without write");
  property p_xov; w1d |=> crossover_auto_enable[0] != $past(reg_write_data[2]); endproperty
  a_xov: assert property (p_xov) else $error("crossover enable wrong");
  property p_mdi; w2d |=> force_mdi[1] == $past(reg_write_data[1]); endproperty
  a_mdi: assert property (p_mdi) else $error("force mdi wrong");
  property p_lb1; w1d |=> loopback_enable[0] == $past(reg_write_data[0]); endproperty
  a_lb1: assert property (p_lb1) else $error("loopback one wrong");
  property p_lb2; w2d |=> loopback_enable[1] == $past(reg_write_data[0]); endproperty
  a_lb2: assert property (p_lb2) else $error("loopback two wrong");
  property p_sts; reg_read && reg_addr == 8'h1E |=> reg_read_data ==
    {$past(phy_crossover_mdix[0], 2), $past(phy_negotiation_complete[0], 2), 6'h00}; endproperty
  a_sts: assert property (p_sts) else $error("status read wrong");
  property p_unm; reg_read && reg_addr == 8'h3D |=> reg_read_data == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("reserved read not zero");
  property p_sts2; reg_read && reg_addr == 8'h2E |=> reg_read_data ==
    {$past(phy_crossover_mdix[1], 2), $past(phy_negotiation_complete[1], 2), 6'h00}; endproperty
  a_sts2: assert property (p_sts2) else $error("status two read wrong");
  property p_adv2; w1c |=> advertise_10_half[0] == $past(reg_write_data[0]); endproperty
  a_adv2: assert property (p_adv2) else $error("half duplex advertise wrong");
  property p_fef; w1d |=> port1_far_end_fault_disable == $past(reg_write_data[4]); endproperty
  a_fef: assert property (p_fef) else $error("far-end fault disable wrong");
  property p_neg; w2c |=> negotiation_enable[1] == $past(reg_write_data[7]); endproperty
  a_neg: assert property (p_neg) else $error("negotiation enable wrong");
  property p_pdn; w2d |=> power_down[1] == $past(reg_write_data[3]); endproperty
  a_pdn: assert property (p_pdn) else $error("power down wrong");
  property p_ind; w1d && !reg_write_data[7] ##1 !w1d |=> port1_indicator_pin == $past(port1_indicator_raw); endproperty
  a_ind: assert property (p_ind) else $error("indicators not following raw");
endmodule : port_phy_properties

// >>> testbench/phy_partner.sv
/* Behavioural PHY and link partner model.
   Assumes the bank's PHY control outputs as inputs. */
`timescale 1ns/1ps
module phy_partner (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control from the bank.
  input wire logic [1:0] negotiation_restart,
  input wire logic [1:0] crossover_auto_enable,
  input wire logic [1:0] force_mdi,
  // Status to the bank.
  output logic [1:0] phy_crossover_mdix,
  output logic [1:0] phy_negotiation_complete,
  output logic [3:0] port1_indicator_raw,
  output logic [3:0] port2_indicator_raw
);
  logic [5:0] tick;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 6'h00;
      phy_negotiation_complete <= 2'h0;
      phy_crossover_mdix <= 2'h0;
    end else begin
      tick <= tick + 6'h01;
      for (int i = 0; i < 2; i++) begin
        phy_negotiation_complete[i] <= !negotiation_restart[i] && (phy_negotiation_complete[i] || tick[2:0] == 3'h7);
        phy_crossover_mdix[i] <= crossover_auto_enable[i] ? tick[5] : !force_mdi[i];
      end
    end
  end
  assign port1_indicator_raw = tick[3:0];
  assign port2_indicator_raw = ~tick[3:0];
endmodule : phy_partner

// >>> testbench/tb_port_phy_control_status.sv
/* Self-checking bench for the port PHY register bank.
   Assumes the design, the PHY model and the checker. */
`timescale 1ns/1ps
module tb_port_phy_control_status;
  logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, pend = 0;
  logic [7:0] reg_addr = 8'h00, reg_write_data = 8'h00, reg_read_data, a, d;
  logic port1_negotiation_strap = 1, port2_negotiation_strap = 0, port2_crossover_strap = 1, port2_force_mdi_strap = 0;
  logic [1:0] phy_crossover_mdix, phy_negotiation_complete, advertise_10_full, advertise_10_half, advertise_100_full,
    advertise_100_half, advertise_pause, negotiation_enable, force_speed_100, force_full_duplex, transmit_disable,
    negotiation_restart, power_down, crossover_auto_enable, force_mdi, loopback_enable;
  logic [3:0] port1_indicator_raw, port2_indicator_raw, port1_indicator_pin, port2_indicator_pin;
  logic port1_far_end_fault_disable;
  logic [7:0] shadow [0:255];
  logic [7:0] exp_q[$], mask_q[$];
  logic [7:0] addrs [7] = '{8'h1C, 8'h1D, 8'h2C, 8'h2D, 8'h3D, 8'h1E, 8'h2E};
  int failures = 0, samples_checked = 0, cycles = 0, seed = 47259;
  port_phy_control_status u_port_phy_control_status (.*);
  phy_partner u_phy_partner (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
    reg_write <= 1;
    reg_read <= 0;
    reg_addr <= wa;
    reg_write_data <= wd;
    if (wa == 8'h1D) shadow[wa] = wd;
    if (wa == 8'h2D) shadow[wa] = wd & 8'hEF;
    if (wa == 8'h1C || wa == 8'h2C) shadow[wa] = wd;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] ra);
    reg_write <= 0;
    reg_read <= 1;
    reg_addr <= ra;
    mask_q.push_back((ra == 8'h1E || ra == 8'h2E) ? 8'h3F : 8'hFF);
    exp_q.push_back(shadow[ra] & mask_q[$]);
    shadow[8'h1D][5] = 1'b0;
    shadow[8'h2D][5] = 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic reset_and_read;
    reg_write <= 0;
    reg_read <= 0;
    @(posedge clk);
    reset_n <= 0;
    port1_negotiation_strap <= 1'($random(seed));
    port2_negotiation_strap <= 1'($random(seed));
    port2_crossover_strap <= 1'($random(seed));
    port2_force_mdi_strap <= 1'($random(seed));
    repeat (12) @(posedge clk);
    reset_n <= 1;
    foreach (shadow[i]) shadow[i] = 8'h00;
    shadow[8'h1C] = {port1_negotiation_strap, 7'h0F};
    shadow[8'h2C] = {port2_negotiation_strap, 7'h0F};
    shadow[8'h2D] = {5'h00, port2_crossover_strap, port2_force_mdi_strap, 1'b0};
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) rd(addrs[i]);
    reg_read <= 0;
    repeat (2) @(posedge clk);
  endtask : reset_and_read
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) pend <= reg_read && reset_n;
  always @(negedge clk) begin
    if (pend) check(reg_read_data & mask_q.pop_front(), exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    @(posedge clk);
    for (int r = 0; r < 2; r++) begin
      reset_and_read();
      for (int i = 0; i < 60; i++) begin
        a = addrs[$unsigned($random(seed)) % 7];
        d = 8'($random(seed));
        wr(a, d);
        rd(a);
        rd(8'h1E);
      end
    end
    reg_read <= 0;
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_port_phy_control_status
bind port_phy_control_status port_phy_properties u_port_phy_properties (.*);
